// ---- rtl/rtcbt_core.sv ----
// Backup-domain time base: source select, prescaler, 32-bit counter,
// alarm, periodic tick, calibration output and backup words.
// Assumes an AXI4-Lite master on clk_i and asynchronous source pins.
// Behaviour
// - Free-running 32-bit counter advanced by time base
// - Alarm when counter reaches programmed compare value
// - Alarm and periodic interrupt sources
// - 20-bit programmable divider makes the time base
// - Divider reset value gives 1 s at 32.768 kHz
// - Source: external 32.768k, internal RC, fast/128
// - 512 Hz calibration output from source clock
// - Ten 16-bit backup words, battery-backed
// - Alarm feeds the external event line unit
// - Alarm leaves Standby mode
// - Time base keeps running in Stop/Standby
// - Backup words preserved through Standby
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
module rtcbt_core
    import rtcbt_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire rtcbt_pins_s pins_i,
    input  wire rtcbt_pwr_s  pwr_i,
    output logic             irq_o,
    output logic             cal_o,
    output logic             alarm_wake_o,
    output logic             standby_exit_o,
    output logic             battery_sel_o
);
    localparam int unsigned HW = $clog2(HSE_DIV);
    localparam int unsigned CW = $clog2(CAL_HALF);

    typedef struct packed {
        logic [3:0][2:0]               sync;
        logic [3:0]                    lvl;
        logic [HW-1:0]                 hdiv;
        logic [CW-1:0]                 ccnt;
        logic                          cal;
        logic                          step;
        rtcbt_src_e                    src;
        logic                          cen;
        logic                          calen;
        logic [1:0]                    stat;
        logic [1:0]                    mask;
        logic [PRESC_W-1:0]            presc;
        logic [31:0]                   cnt;
        logic [31:0]                   alrm;
        logic [BKP_NUM-1:0][BKP_W-1:0] bkp;
        logic                          awh;
        logic [7:0]                    awa;
        logic                          wh;
        logic [31:0]                   wd;
        logic [3:0]                    ws;
        logic                          bv;
        logic [1:0]                    br;
        logic                          rv;
        logic [31:0]                   rd;
        logic [1:0]                    rr;
        logic                          wake;
        logic                          sbx;
    } rtcbt_core_s;

    rtcbt_core_s        s;
    rtcbt_core_s        next_s;
    logic [3:0]         pin_v;
    logic [3:0]         rise;
    logic               sel;
    logic               tick;
    logic               hit;
    logic               wdo;
    logic [1:0]         clr;
    logic [1:0]         set;
    logic [31:0]        w;
    logic [31:0]        nxt_cnt;
    logic [PRESC_W-1:0] divcnt;

    // Backup word address check
    function automatic logic is_bkp(input logic [7:0] a);
        return a[1:0] == 2'h0 && a >= OFS_BKP0 && a < OFS_BKP0 + 8'(4 * BKP_NUM);
    endfunction

    function automatic logic [3:0] bkp_idx(input logic [7:0] a);
        return 4'((a - OFS_BKP0) >> 2);
    endfunction

    // Any register at this address
    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0 && a <= OFS_ALRM) || is_bkp(a);
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Register view at an address
    function automatic logic [31:0] view(input rtcbt_core_s st, input logic [7:0] a,
                                         input logic [PRESC_W-1:0] dc);
        logic [31:0] r;
        r = 32'h0;
        if (is_bkp(a))
        begin
            r = {16'h0, st.bkp[bkp_idx(a)]};
        end
        else
        begin
            case (a)
                OFS_CTRL:  r = {28'h0, st.calen, st.cen, st.src};
                OFS_STAT:  r = {30'h0, st.stat};
                OFS_MASK:  r = {30'h0, st.mask};
                OFS_PRESC: r = {12'h0, st.presc};
                OFS_DIV:   r = {12'h0, dc};
                OFS_CNT:   r = st.cnt;
                OFS_ALRM:  r = st.alrm;
                default:   r = 32'h0;
            endcase
        end
        return r;
    endfunction

    assign pin_v = pins_i;

    rtcbt_tick_div #(
        .PW      (PRESC_W)
    ) u_div (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .ce_i    (ce_i),
        .step_i  (s.step),
        .load_i  (s.presc),
        .tick_o  (tick),
        .count_o (divcnt)
    );

    // Next-state logic of the whole block
    always_comb
    begin
        next_s  = s;
        rise    = 4'h0;
        sel     = 1'b0;
        hit     = 1'b0;
        wdo     = 1'b0;
        clr     = 2'h0;
        set     = 2'h0;
        w       = 32'h0;
        nxt_cnt = s.cnt + 32'h1;

        // Three-stage pin sync, level moves when stages 2 and 3 agree
        for (int i = 0; i < 4; i++)
        begin
            next_s.sync[i] = {s.sync[i][1:0], pin_v[i]};
            if (s.sync[i][1] == s.sync[i][2])
            begin
                next_s.lvl[i] = s.sync[i][2];
                rise[i]       = s.sync[i][2] & ~s.lvl[i];
            end
        end

        // Source selection, fast clock divided by 128
        if (rise[2])
        begin
            next_s.hdiv = s.hdiv + 1'b1;
        end
        unique case (s.src)
            SRC_LSE: sel = rise[0];
            SRC_LSI: sel = rise[1];
            SRC_HSE: sel = rise[2] && s.hdiv == HW'(HSE_DIV - 1);
            default: sel = rise[0];
        endcase
        // Stop and Standby levels do not gate the time base
        next_s.step = sel && s.cen;

        // Calibration square wave, one toggle per 32 source edges
        if (!s.calen)
        begin
            next_s.ccnt = '0;
            next_s.cal  = 1'b0;
        end
        else if (sel)
        begin
            next_s.ccnt = s.ccnt + 1'b1;
            if (s.ccnt == CW'(CAL_HALF - 1))
            begin
                next_s.cal = ~s.cal;
            end
        end

        // Counter advance, alarm compare and periodic event
        if (tick)
        begin
            next_s.cnt     = nxt_cnt;
            set[ST_PERIOD] = 1'b1;
            if (nxt_cnt == s.alrm)
            begin
                hit           = 1'b1;
                set[ST_ALARM] = 1'b1;
            end
        end
        next_s.wake = hit;
        next_s.sbx  = hit && pwr_i.standby;

        // Write address and data captured in either order
        if (s_axi_awvalid && !s.awh)
        begin
            next_s.awh = 1'b1;
            next_s.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.wh)
        begin
            next_s.wh = 1'b1;
            next_s.wd = s_axi_wdata;
            next_s.ws = s_axi_wstrb;
        end
        if (s.bv && s_axi_bready)
        begin
            next_s.bv = 1'b0;
        end

        // Write execution, refused in Standby and off the map
        if (s.awh && s.wh && !s.bv)
        begin
            next_s.awh = 1'b0;
            next_s.wh  = 1'b0;
            next_s.bv  = 1'b1;
            next_s.br  = RESP_OKAY;
            w = merge(view(s, s.awa, divcnt), s.wd, s.ws);
            if (pwr_i.standby || !mapped(s.awa))
            begin
                next_s.br = RESP_SLV;
            end
            else if (is_bkp(s.awa))
            begin
                wdo = 1'b1;
                next_s.bkp[bkp_idx(s.awa)] = w[BKP_W-1:0];
            end
            else
            begin
                wdo = 1'b1;
                case (s.awa)
                    OFS_CTRL:
                    begin
                        if (w[1:0] <= SRC_HSE)
                        begin
                            next_s.src = rtcbt_src_e'(w[1:0]);
                        end
                        next_s.cen   = w[CTRL_CEN];
                        next_s.calen = w[CTRL_CAL];
                    end
                    OFS_STAT:  clr          = s.wd[1:0] & {2{s.ws[0]}};
                    OFS_MASK:  next_s.mask  = w[1:0];
                    OFS_PRESC: next_s.presc = w[PRESC_W-1:0];
                    OFS_CNT:   next_s.cnt   = w;
                    OFS_ALRM:  next_s.alrm  = w;
                    default:   next_s.br    = RESP_OKAY;
                endcase
            end
        end
        // Write-one-to-clear, a same-cycle event wins
        next_s.stat = (s.stat & ~clr) | set;

        // Read path, data one cycle after the address
        if (s.rv && s_axi_rready)
        begin
            next_s.rv = 1'b0;
        end
        if (s_axi_arvalid && !s.rv)
        begin
            next_s.rv = 1'b1;
            next_s.rd = view(s, s_axi_araddr, divcnt);
            next_s.rr = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLV;
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s       <= '0;
            s.lvl   <= LVL_RST;
            s.sync[3] <= {3{LVL_RST[3]}};  // Supply pin idles high, no false loss at start
            s.src   <= SRC_LSE;
            s.cen   <= 1'b1;
            s.presc <= PRESC_RST;
            s.alrm  <= ALARM_RST;
        end
        else if (ce_i)
        begin
            s <= next_s;
        end
    end

    // Port drive
    assign s_axi_awready  = ce_i & ~s.awh;
    assign s_axi_wready   = ce_i & ~s.wh;
    assign s_axi_bvalid   = s.bv;
    assign s_axi_bresp    = s.br;
    assign s_axi_arready  = ce_i & ~s.rv;
    assign s_axi_rvalid   = s.rv;
    assign s_axi_rdata    = s.rd;
    assign s_axi_rresp    = s.rr;
    assign irq_o          = |(s.stat & s.mask);
    assign cal_o          = s.cal;
    assign alarm_wake_o   = s.wake;
    assign standby_exit_o = s.sbx;
    assign battery_sel_o  = ~s.lvl[3];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    sequence s_tick_free;
        tick && !(wdo && s.awa == OFS_CNT);
    endsequence

    sequence s_hse_wrap;
        s.src == SRC_HSE && rise[2] && s.hdiv == HW'(HSE_DIV - 1);
    endsequence

    property p_cnt_step;
        s_tick_free |=> s.cnt == $past(s.cnt) + 32'h1;
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("counter missed a tick");

    property p_alarm;
        tick && nxt_cnt == s.alrm |=> s.stat[ST_ALARM] && (irq_o || !s.mask[ST_ALARM]);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm flag not set on match");

    property p_set_wins;
        tick && wdo && s.awa == OFS_STAT && s.ws[0] && s.wd[ST_PERIOD] |=> s.stat[ST_PERIOD];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("periodic event lost to clear");

    property p_presc_rst;
        $past(srst_i) |-> s.presc == PRESC_RST && divcnt == PRESC_RST;
    endproperty
    a_presc_rst: assert property (p_presc_rst) else $error("prescaler reset value wrong");

    property p_hse;
        s_hse_wrap ##0 s.cen |=> s.step;
    endproperty
    a_hse: assert property (p_hse) else $error("fast source divide missed");

    property p_cal;
        s.calen && sel && s.ccnt == CW'(CAL_HALF - 1) |=> cal_o != $past(cal_o);
    endproperty
    a_cal: assert property (p_cal) else $error("calibration output did not toggle");

    property p_batt;
        !s.sync[3][1] && !s.sync[3][2] |=> battery_sel_o;
    endproperty
    a_batt: assert property (p_batt) else $error("battery not selected");

    property p_wake;
        hit |=> alarm_wake_o;
    endproperty
    a_wake: assert property (p_wake) else $error("alarm not sent to event line");

    property p_sb_exit;
        hit && pwr_i.standby |=> standby_exit_o && alarm_wake_o;
    endproperty
    a_sb_exit: assert property (p_sb_exit) else $error("alarm did not leave Standby");

    property p_lowpower;
        s_tick_free ##0 (pwr_i.stop || pwr_i.standby) |=> s.cnt == $past(s.cnt) + 32'h1;
    endproperty
    a_lowpower: assert property (p_lowpower) else $error("counter stalled in low power");

    property p_bkp_keep;
        pwr_i.standby |=> $stable(s.bkp);
    endproperty
    a_bkp_keep: assert property (p_bkp_keep) else $error("backup word changed in Standby");
endmodule

// ---- rtl/rtcbt_pkg.sv ----
// Shared constants and carrier types of the backup time base.
// Assumes a single 100 MHz system clock; source clocks arrive as pins.
package rtcbt_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_MASK  = 8'h08;
    localparam logic [7:0] OFS_PRESC = 8'h0C;
    localparam logic [7:0] OFS_DIV   = 8'h10;
    localparam logic [7:0] OFS_CNT   = 8'h14;
    localparam logic [7:0] OFS_ALRM  = 8'h18;
    localparam logic [7:0] OFS_BKP0  = 8'h20;

    // Field positions
    localparam int unsigned CTRL_CEN  = 2;
    localparam int unsigned CTRL_CAL  = 3;
    localparam int unsigned ST_ALARM  = 0;
    localparam int unsigned ST_PERIOD = 1;

    // Sizes, reset values and divide counts
    localparam int unsigned BKP_NUM   = 10;
    localparam int unsigned BKP_W     = 16;
    localparam int unsigned PRESC_W   = 20;
    localparam logic [19:0] PRESC_RST = 20'h07FFF;
    localparam logic [31:0] ALARM_RST = 32'hFFFFFFFF;
    localparam logic [3:0]  LVL_RST   = 4'h8;
    localparam int unsigned HSE_DIV   = 128;
    localparam int unsigned CAL_HALF  = 32;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;

    typedef enum logic [1:0] {SRC_LSE, SRC_LSI, SRC_HSE} rtcbt_src_e;

    // Asynchronous pins, bit 3 first
    typedef struct packed {
        logic main_ok;
        logic hse;
        logic lsi;
        logic lse;
    } rtcbt_pins_s;

    // Power mode levels from the power controller
    typedef struct packed {
        logic stop;
        logic standby;
    } rtcbt_pwr_s;
endpackage

// ---- rtl/rtcbt_tick_div.sv ----
// Reloading down-counter that turns source edges into time-base ticks.
// Assumes step_i is a one-cycle pulse per source clock edge.
module rtcbt_tick_div
    import rtcbt_pkg::*;
#(
    parameter int unsigned PW = PRESC_W
)
(
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    input  wire logic          ce_i,
    input  wire logic          step_i,
    input  wire logic [PW-1:0] load_i,
    output logic               tick_o,
    output logic [PW-1:0]      count_o
);
    typedef struct packed {
        logic [PW-1:0] cnt;
        logic          tick;
    } rtcbt_div_s;

    rtcbt_div_s s;
    rtcbt_div_s next_s;

    // Count down, reload and tick on expiry
    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (step_i)
        begin
            if (s.cnt == '0)
            begin
                next_s.cnt  = load_i;
                next_s.tick = 1'b1;
            end
            else
            begin
                next_s.cnt = s.cnt - 1'b1;
            end
        end
    end

    // State register, preset for one tick per 32768 edges
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s.cnt  <= PW'(PRESC_RST);
            s.tick <= 1'b0;
        end
        else if (ce_i)
        begin
            s <= next_s;
        end
    end

    assign tick_o  = s.tick;
    assign count_o = s.cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    property p_reload;
        step_i && s.cnt == '0 |=> tick_o && count_o == $past(load_i);
    endproperty
    a_reload: assert property (p_reload) else $error("divider did not reload");

    property p_down;
        step_i && s.cnt != '0 |=> !tick_o && count_o == $past(count_o) - 1'b1;
    endproperty
    a_down: assert property (p_down) else $error("divider did not count down");
endmodule

// ---- testbench/rtcbt_core_tb_top.sv ----
// Self-checking bench of the backup time base core: register map, backup
// words, prescaler, counter, alarm, wake pulses, calibration and sources.
// Assumes the core on one 100 MHz clock, with AXI4-Lite and edge-driven pins.
module rtcbt_core_tb_top
    import rtcbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_i         = 1'b0;
    logic        srst_i        = 1'b1;
    logic        ce_i          = 1'b1;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    rtcbt_pins_s pins_i        = 4'h8;
    rtcbt_pwr_s  pwr_i         = 2'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        irq_o, cal_o, alarm_wake_o, standby_exit_o, battery_sel_o, cal_q;
    logic [33:0] exp_r [$];
    logic [1:0]  exp_b [$];
    logic [15:0] bk [10];
    logic [31:0] lfsr_q = 32'h00000009;
    int          errors, samples_checked, wakes, exits, cal_rises;

    rtcbt_core rtcbt_core_i (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .pins_i(pins_i), .pwr_i(pwr_i),
        .irq_o(irq_o), .cal_o(cal_o), .alarm_wake_o(alarm_wake_o),
        .standby_exit_o(standby_exit_o), .battery_sel_o(battery_sel_o)
    );

    // Free-running 100 MHz clock
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Level check in the settled middle of a cycle
    task automatic chk(input logic got, input logic exp);
        @(negedge clk_i);
        check({33'h0, got}, {33'h0, exp});
        @(posedge clk_i);
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        logic ga;
        logic gw;
        ga = 1'b0;
        gw = 1'b0;
        exp_b.push_back(r);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(negedge clk_i);
            ga = ga | (s_axi_awvalid & s_axi_awready);
            gw = gw | (s_axi_wvalid & s_axi_wready);
            @(posedge clk_i);
            if (ga)
                s_axi_awvalid <= 1'b0;
            if (gw)
                s_axi_wvalid <= 1'b0;
        end
        while (!(ga && gw));
        do @(negedge clk_i); while (s_axi_bvalid !== 1'b1);
        @(posedge clk_i);
    endtask

    // Read: expectation noted for the watcher, then one address beat
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_r.push_back({r, d});
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge clk_i); while (s_axi_arready !== 1'b1);
        @(posedge clk_i);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk_i); while (s_axi_rvalid !== 1'b1);
        @(posedge clk_i);
    endtask

    // Rising edges on one source pin, two cycles high and two low
    task automatic pulses(input int k, input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            pins_i[k] <= 1'b1;
            repeat (2) @(posedge clk_i);
            pins_i[k] <= 1'b0;
            @(posedge clk_i);
        end
        repeat (12) @(posedge clk_i);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watcher: answers against oldest notes, event pulses counted
    always @(negedge clk_i)
    begin
        if (s_axi_rvalid === 1'b1)
            check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
        if (s_axi_bvalid === 1'b1)
            check({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
        if (alarm_wake_o === 1'b1)
            wakes++;
        if (standby_exit_o === 1'b1)
            exits++;
        if (cal_o === 1'b1 && cal_q !== 1'b1)
            cal_rises++;
        cal_q = cal_o;
    end

    // Hang guard, above the ~135k cycles the sequence needs
    initial
    begin
        #1500000;
        errors++;
        conclude();
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rd(OFS_CTRL, 32'h4, RESP_OKAY);
        rd(OFS_STAT, 32'h0, RESP_OKAY);
        rd(OFS_MASK, 32'h0, RESP_OKAY);
        rd(OFS_PRESC, 32'(32768 - 1), RESP_OKAY);
        rd(OFS_CNT, 32'h0, RESP_OKAY);
        rd(OFS_ALRM, 32'hFFFFFFFF, RESP_OKAY);
        wr(OFS_DIV, 32'h0, 4'hF, RESP_OKAY);
        rd(OFS_DIV, 32'(32768 - 1), RESP_OKAY);
        rd(8'h1C, 32'h0, RESP_SLV);
        wr(8'h48, 32'h1, 4'hF, RESP_SLV);
        chk(irq_o, 1'b0);
        chk(battery_sel_o, 1'b0);
        $display("test reset_map done");
        // Backup words with random data, then one partial strobe
        for (int i = 0; i < 10; i++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            bk[i] = lfsr_q[15:0];
            wr(OFS_BKP0 + 8'(4 * i), lfsr_q, 4'hF, RESP_OKAY);
            rd(OFS_BKP0 + 8'(4 * i), {16'h0, bk[i]}, RESP_OKAY);
        end
        wr(OFS_BKP0 + 8'h08, 32'hFFFFFFFF, 4'h2, RESP_OKAY);
        bk[2][15:8] = 8'hFF;
        rd(OFS_BKP0 + 8'h08, {16'h0, bk[2]}, RESP_OKAY);
        $display("test backup done");
        // First tick only after the full default divide of 32768 edges
        wr(OFS_CTRL, 32'hC, 4'hF, RESP_OKAY);
        wr(OFS_PRESC, 32'h1, 4'hF, RESP_OKAY);
        wr(OFS_MASK, 32'h3, 4'hF, RESP_OKAY);
        wr(OFS_ALRM, 32'h4, 4'hF, RESP_OKAY);
        pwr_i.stop <= 1'b1;
        pulses(0, 32767);
        rd(OFS_CNT, 32'h0, RESP_OKAY);
        rd(OFS_STAT, 32'h0, RESP_OKAY);
        pulses(0, 1);
        rd(OFS_CNT, 32'h1, RESP_OKAY);
        rd(OFS_STAT, 32'h2, RESP_OKAY);
        rd(OFS_DIV, 32'h1, RESP_OKAY);
        chk(irq_o, 1'b1);
        check(34'(cal_rises), 34'd512);
        $display("test time_base done");
        // Alarm match in Standby with a short reload
        wr(OFS_STAT, 32'h3, 4'hF, RESP_OKAY);
        pwr_i.standby <= 1'b1;
        pulses(0, 6);
        rd(OFS_CNT, 32'h4, RESP_OKAY);
        rd(OFS_STAT, 32'h3, RESP_OKAY);
        check(34'(wakes), 34'd1);
        check(34'(exits), 34'd1);
        wr(OFS_BKP0 + 8'h04, 32'h0, 4'hF, RESP_SLV);
        pins_i.main_ok <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk(battery_sel_o, 1'b1);
        rd(OFS_BKP0 + 8'h04, {16'h0, bk[1]}, RESP_OKAY);
        pwr_i.standby <= 1'b0;
        pins_i.main_ok <= 1'b1;
        $display("test alarm_standby done");
        // Sticky status, write-one clear and masking
        wr(OFS_STAT, 32'h1, 4'hF, RESP_OKAY);
        rd(OFS_STAT, 32'h2, RESP_OKAY);
        wr(OFS_MASK, 32'h1, 4'hF, RESP_OKAY);
        chk(irq_o, 1'b0);
        wr(OFS_MASK, 32'h2, 4'hF, RESP_OKAY);
        chk(irq_o, 1'b1);
        wr(OFS_STAT, 32'h2, 4'hF, RESP_OKAY);
        chk(irq_o, 1'b0);
        $display("test interrupt done");
        // Other sources, frozen clock enable, invalid select, counting off
        wr(OFS_CNT, 32'h0, 4'hF, RESP_OKAY);
        wr(OFS_CTRL, 32'h5, 4'hF, RESP_OKAY);
        pulses(1, 4);
        rd(OFS_CNT, 32'h2, RESP_OKAY);
        ce_i <= 1'b0;
        pulses(1, 4);
        chk(s_axi_awready, 1'b0);
        ce_i <= 1'b1;
        rd(OFS_CNT, 32'h2, RESP_OKAY);
        wr(OFS_CTRL, 32'h6, 4'hF, RESP_OKAY);
        pulses(2, 512);
        rd(OFS_CNT, 32'h4, RESP_OKAY);
        check(34'(wakes), 34'd2);
        check(34'(exits), 34'd1);
        chk(cal_o, 1'b0);
        wr(OFS_CTRL, 32'h7, 4'hF, RESP_OKAY);
        rd(OFS_CTRL, 32'h6, RESP_OKAY);
        wr(OFS_CTRL, 32'h0, 4'hF, RESP_OKAY);
        pulses(0, 4);
        rd(OFS_CNT, 32'h4, RESP_OKAY);
        $display("test sources done");
        conclude();
    end
endmodule
